/* hdl/sgp_params.svh */
`ifndef SGP_PARAMS_SVH
`define SGP_PARAMS_SVH

// modulator word and result widths
`define SGP_MOD_W 32
`define SGP_RES_W 24
// lsb position of the kept field per digital gain
`define SGP_LSB_G1 8
`define SGP_LSB_G2 7
`define SGP_LSB_G4 6
// path select codes
`define SGP_SEL_BYPASS 2'h0
`define SGP_SEL_BUFFER 2'h1
`define SGP_SEL_PGA 2'h2
// spare code, taken as bypass
`define SGP_SEL_SPARE 2'h3
// gain field codes
`define SGP_GAIN_X1 3'h0
`define SGP_GAIN_X2 3'h1
`define SGP_GAIN_X4 3'h2
// single-cycle sinc4 rate divider
`define SGP_SINC4_DIV 3'h4
`define SGP_CNT_LAST 2'h3
// reset values
`define SGP_RST_GAIN 3'h0
`define SGP_RST_RES 24'h000000
`define SGP_RST_CNT 2'h0

`endif

/* hdl/sgp_pkg.sv */
package sgp_pkg;

    // selected signal path
    typedef enum logic [1:0] {
        SGP_PATH_BYPASS,
        SGP_PATH_BUFFER,
        SGP_PATH_PGA
    } sgp_path_type;

    // effective digital gain
    typedef enum logic [1:0] {
        SGP_DG_X1,
        SGP_DG_X2,
        SGP_DG_X4
    } sgp_dgain_type;

    // whole block state
    typedef struct packed {
        sgp_path_type path;
        logic bypass_sw;
        logic buf_en;
        logic pga_en;
        logic pga_in_sw;
        logic pga_out_sw;
        logic [2:0] pga_gain;
        sgp_dgain_type dgain;
        logic [23:0] result;
        logic result_valid;
        logic result_bipolar;
        logic [1:0] rate_cnt;
    } sgp_state_type;

endpackage

/* hdl/sgp_signal_path.sv */
// What this block does
// - pick exactly one of three input paths
// - bypass: mux to modulator, buffers and amplifier off
// - buffered: buffers on, amplifier kept off
// - amplifier: amplifier on and wired, buffers off
// - amplifier gains one to 128, powers of two
// - direct and buffered: digital gain 2 or 4
// - digital gain codes two or above give four
// - unity gain: drop eight lsbs of 32
// - gain two: drop msb and seven lsbs
// - full scale is reference over gain
// - sinc4 single-cycle rate is continuous over four
`timescale 1ns/10ps
`default_nettype none
`include "sgp_params.svh"

module sgp_signal_path
    import sgp_pkg::*;
#(
    parameter int MOD_W = `SGP_MOD_W,
    parameter int RES_W = `SGP_RES_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] path_sel,
    input wire logic [2:0] gain_code,
    input wire logic bipolar,
    input wire logic filter_sinc4,
    input wire logic single_cycle,
    input wire logic mod_valid,
    input wire logic [MOD_W-1:0] mod_word,
    output logic bypass_sw,
    output logic buf_en,
    output logic pga_en,
    output logic pga_in_sw,
    output logic pga_out_sw,
    output logic [2:0] pga_gain,
    output logic [1:0] dgain,
    output logic [RES_W-1:0] result,
    output logic result_valid,
    output logic result_bipolar
);

    ////////////////////////////////////////////////////////////////////////
    // state and decode

    sgp_state_type state_reg; // all block state
    sgp_state_type state_next; // next value of the state
    sgp_path_type path_dec; // decoded path select
    sgp_dgain_type dgain_dec; // decoded digital gain
    logic sinc4_single; // quarter-rate output mode
    logic take_now; // this word yields a result
    logic [RES_W-1:0] cut_word; // result cut from the word

    // path select decode, illegal code falls back to bypass
    always_comb begin
        unique case (path_sel)
            `SGP_SEL_BYPASS: path_dec = SGP_PATH_BYPASS;
            `SGP_SEL_BUFFER: path_dec = SGP_PATH_BUFFER;
            `SGP_SEL_PGA: path_dec = SGP_PATH_PGA;
            default: path_dec = SGP_PATH_BYPASS;
        endcase
    end

    // digital gain decode, amplifier path always unity
    always_comb begin
        if (path_dec == SGP_PATH_PGA) begin
            dgain_dec = SGP_DG_X1;
        end else if (gain_code == `SGP_GAIN_X1) begin
            dgain_dec = SGP_DG_X1;
        end else if (gain_code == `SGP_GAIN_X2) begin
            dgain_dec = SGP_DG_X2;
        end else begin
            // any larger setting saturates at four
            dgain_dec = SGP_DG_X4;
        end
    end

    // result field select, a shift by one bit per gain step
    always_comb begin
        unique case (dgain_dec)
            SGP_DG_X1: cut_word = mod_word[`SGP_LSB_G1 +: RES_W];
            SGP_DG_X2: cut_word = mod_word[`SGP_LSB_G2 +: RES_W];
            SGP_DG_X4: cut_word = mod_word[`SGP_LSB_G4 +: RES_W];
            default: cut_word = mod_word[`SGP_LSB_G1 +: RES_W];
        endcase
    end

    // output rate decision
    assign sinc4_single = filter_sinc4 & single_cycle;
    // one word in four when sinc4 single-cycle, else every word
    assign take_now = mod_valid & (~sinc4_single | (state_reg.rate_cnt == `SGP_CNT_LAST));

    ////////////////////////////////////////////////////////////////////////
    // next state

    // fills the whole next state from inputs and state
    always_comb begin
        state_next = state_reg;
        state_next.path = path_dec;
        // defaults: all path elements off
        state_next.bypass_sw = 1'b0;
        state_next.buf_en = 1'b0;
        state_next.pga_en = 1'b0;
        state_next.pga_in_sw = 1'b0;
        state_next.pga_out_sw = 1'b0;
        state_next.pga_gain = `SGP_RST_GAIN;
        state_next.dgain = dgain_dec;
        state_next.result_valid = 1'b0;
        unique case (path_dec)
            SGP_PATH_BYPASS: begin
                // mux drives modulator directly
                state_next.bypass_sw = 1'b1;
            end
            SGP_PATH_BUFFER: begin
                // low-power buffers in the path
                state_next.buf_en = 1'b1;
            end
            SGP_PATH_PGA: begin
                // amplifier powered and switched in
                state_next.pga_en = 1'b1;
                state_next.pga_in_sw = 1'b1;
                state_next.pga_out_sw = 1'b1;
                // gain is two to the power of the code
                state_next.pga_gain = gain_code;
            end
        endcase
        // rate counter only runs in quarter-rate mode
        if (!sinc4_single) begin
            state_next.rate_cnt = `SGP_RST_CNT;
        end else if (mod_valid) begin
            // wraps after the last of four words
            state_next.rate_cnt = state_reg.rate_cnt + 2'h1;
        end
        // capture a result
        if (take_now) begin
            state_next.result = cut_word;
            state_next.result_valid = 1'b1;
            state_next.result_bipolar = bipolar;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // registers the whole state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg.path <= SGP_PATH_BYPASS;
            state_reg.bypass_sw <= 1'b1;
            state_reg.buf_en <= 1'b0;
            state_reg.pga_en <= 1'b0;
            state_reg.pga_in_sw <= 1'b0;
            state_reg.pga_out_sw <= 1'b0;
            state_reg.pga_gain <= `SGP_RST_GAIN;
            state_reg.dgain <= SGP_DG_X1;
            state_reg.result <= `SGP_RST_RES;
            state_reg.result_valid <= 1'b0;
            state_reg.result_bipolar <= 1'b0;
            state_reg.rate_cnt <= `SGP_RST_CNT;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, straight from the state register

    assign bypass_sw = state_reg.bypass_sw;
    assign buf_en = state_reg.buf_en;
    assign pga_en = state_reg.pga_en;
    assign pga_in_sw = state_reg.pga_in_sw;
    assign pga_out_sw = state_reg.pga_out_sw;
    assign pga_gain = state_reg.pga_gain;
    assign dgain = state_reg.dgain;
    assign result = state_reg.result;
    assign result_valid = state_reg.result_valid;
    assign result_bipolar = state_reg.result_bipolar;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // a word accepted at a given digital gain code on a direct path
    sequence s_word_g1;
        mod_valid && take_now && path_sel == `SGP_SEL_BUFFER && gain_code == `SGP_GAIN_X1;
    endsequence
    sequence s_word_g2;
        mod_valid && take_now && path_sel == `SGP_SEL_BYPASS && gain_code == `SGP_GAIN_X2;
    endsequence
    sequence s_word_g4;
        mod_valid && take_now && path_sel == `SGP_SEL_BYPASS && gain_code >= `SGP_GAIN_X4;
    endsequence
    // last word of four in quarter-rate mode
    sequence s_last_of_four;
        mod_valid && sinc4_single && state_reg.rate_cnt == `SGP_CNT_LAST;
    endsequence

    // exactly one path element group active
    a_one_path: assert property ($onehot({bypass_sw, buf_en, pga_en}))
        else $error("not exactly one signal path active");

    // bypass selection turns off buffers and amplifier
    a_bypass_path: assert property (
        path_sel == `SGP_SEL_BYPASS |=> bypass_sw && !buf_en && !pga_en)
        else $error("bypass path not set up");

    // buffered selection keeps amplifier off
    a_buffer_path: assert property (
        path_sel == `SGP_SEL_BUFFER |=> buf_en && !pga_en && !bypass_sw && !pga_in_sw)
        else $error("buffered path not set up");

    // amplifier selection powers and wires amplifier
    a_pga_path: assert property (
        path_sel == `SGP_SEL_PGA |=> pga_en && pga_in_sw && pga_out_sw && !buf_en && !bypass_sw)
        else $error("amplifier path not set up");

    // amplifier gain follows the code, digital gain unity
    a_pga_gain: assert property (
        path_sel == `SGP_SEL_PGA |=> pga_gain == $past(gain_code) && dgain == SGP_DG_X1)
        else $error("amplifier gain wrong");

    // gain code two or more saturates at four on direct paths
    a_dgain_sat: assert property (
        path_sel != `SGP_SEL_PGA && gain_code >= `SGP_GAIN_X4 |=> dgain == SGP_DG_X4)
        else $error("digital gain not saturated at four");

    // gain two code on a direct path
    a_dgain_two: assert property (
        path_sel == `SGP_SEL_BUFFER && gain_code == `SGP_GAIN_X2 |=> dgain == SGP_DG_X2)
        else $error("digital gain two not applied");

    // unity gain drops eight lsbs
    a_cut_unity: assert property (
        s_word_g1 |=> result_valid && result == $past(mod_word[31:8]))
        else $error("unity gain result field wrong");

    // gain two drops msb and seven lsbs
    a_cut_two: assert property (
        s_word_g2 |=> result_valid && result == $past(mod_word[30:7]))
        else $error("gain two result field wrong");

    // gain four drops two msbs and six lsbs
    a_cut_four: assert property (
        s_word_g4 |=> result_valid && result == $past(mod_word[29:6]))
        else $error("gain four result field wrong");

    // result carries the polarity it was taken with
    a_polarity_tag: assert property (
        take_now |=> result_bipolar == $past(bipolar))
        else $error("result polarity tag wrong");

    // quarter-rate mode: first three words of four give nothing
    a_quarter_rate: assert property (
        mod_valid && sinc4_single && state_reg.rate_cnt != `SGP_CNT_LAST |=> !result_valid)
        else $error("sinc4 single-cycle result too early");

    // continuous or fir: every word gives a result
    a_full_rate: assert property (
        mod_valid && !sinc4_single |=> result_valid)
        else $error("full-rate result missing");

    // spare path code behaves as bypass
    a_spare_code: assert property (
        path_sel == `SGP_SEL_SPARE |=> bypass_sw && !buf_en && !pga_en && !pga_in_sw && !pga_out_sw)
        else $error("spare path code not taken as bypass");

    // amplifier switches open off the amplifier path
    a_switch_open: assert property (
        path_sel != `SGP_SEL_PGA |=> !pga_in_sw && !pga_out_sw)
        else $error("amplifier switch closed off the amplifier path");

    // analog gain code parked off the amplifier path
    a_gain_idle: assert property (
        path_sel != `SGP_SEL_PGA |=> pga_gain == `SGP_RST_GAIN)
        else $error("analog gain code not parked");

    // recorded path agrees with the enables
    a_path_record: assert property (
        (state_reg.path == SGP_PATH_BYPASS) == bypass_sw && (state_reg.path == SGP_PATH_BUFFER) == buf_en
        && (state_reg.path == SGP_PATH_PGA) == pga_en)
        else $error("recorded path disagrees with enables");

    // unity code on a direct path keeps unity gain
    a_dgain_unity: assert property (
        path_sel != `SGP_SEL_PGA && gain_code == `SGP_GAIN_X1 |=> dgain == SGP_DG_X1)
        else $error("unity digital gain not applied");

    // gain two code on the bypass path
    a_dgain_bypass: assert property (
        path_sel == `SGP_SEL_BYPASS && gain_code == `SGP_GAIN_X2 |=> dgain == SGP_DG_X2)
        else $error("digital gain two not applied on bypass");

    // no word taken: no pulse, result and tag held
    a_result_hold: assert property (
        !take_now |=> !result_valid && $stable(result) && $stable(result_bipolar))
        else $error("result changed without a taken word");

    // counter parked while quarter-rate mode is off
    a_rate_restart: assert property (
        !sinc4_single |=> state_reg.rate_cnt == `SGP_RST_CNT)
        else $error("rate counter not parked");

    // fourth word of four gives a result
    a_quarter_take: assert property (
        s_last_of_four |=> result_valid)
        else $error("sinc4 single-cycle result missing");

endmodule

`default_nettype wire

/* verif/sgp_mod_model.sv */
`timescale 1ns/10ps
`default_nettype none
// modulator stand-in: queued words, optional idle gap
module sgp_mod_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] gap_cycles,
    output logic mod_valid,
    output logic [31:0] mod_word
);
    logic [31:0] pending[$]; // words waiting to go out
    logic [1:0] idle_cnt; // idle cycles since last word
    // queue one word for the modulator output
    task automatic send_word(input logic [31:0] w);
        pending.push_back(w);
    endtask
    ////////////////////////////////////////////////////////////////
    // one word per cycle at most; idle word toggles so no stale match
    always @(negedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mod_valid <= 1'b0;
            mod_word <= 32'h0;
            idle_cnt <= 2'h0;
        end else if (pending.size() != 0 && idle_cnt >= gap_cycles) begin
            mod_valid <= 1'b1;
            mod_word <= pending.pop_front();
            idle_cnt <= 2'h0;
        end else begin
            mod_valid <= 1'b0;
            mod_word <= ~mod_word;
            idle_cnt <= idle_cnt + 2'(idle_cnt != 2'h3);
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sgp_pkg::*;
    logic clock, arst_n, bipolar, filter_sinc4, single_cycle, mod_valid;
    logic [1:0] path_sel, gap_cycles, dgain;
    logic [2:0] gain_code, pga_gain;
    logic [31:0] mod_word;
    logic bypass_sw, buf_en, pga_en, pga_in_sw, pga_out_sw, result_valid, result_bipolar;
    logic [23:0] result;
    int fails = 0; // mismatch count
    int samples_checked = 0; // comparison count
    sgp_signal_path DUT (.clock(clock), .arst_n(arst_n), .path_sel(path_sel), .gain_code(gain_code),
        .bipolar(bipolar), .filter_sinc4(filter_sinc4), .single_cycle(single_cycle),
        .mod_valid(mod_valid), .mod_word(mod_word), .bypass_sw(bypass_sw), .buf_en(buf_en),
        .pga_en(pga_en), .pga_in_sw(pga_in_sw), .pga_out_sw(pga_out_sw), .pga_gain(pga_gain),
        .dgain(dgain), .result(result), .result_valid(result_valid), .result_bipolar(result_bipolar));
    sgp_mod_model u_mod (.clock(clock), .arst_n(arst_n), .gap_cycles(gap_cycles),
        .mod_valid(mod_valid), .mod_word(mod_word));
    ////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // expected result field for path, gain code and word
    function automatic logic [23:0] exp_res(int s, int g, logic [31:0] w);
        if (s == 2 || g == 0) return w[31:8];
        if (g == 1) return w[30:7];
        return w[29:6];
    endfunction
    ////////////////////////////////////////////////////////////////
    // every path and gain code, changing every second cycle
    task automatic test_paths();
        for (int s = 0; s < 4; s++) begin
            for (int g = 0; g < 8; g++) begin
                @(negedge clock);
                path_sel = 2'(s);
                gain_code = 3'(g);
                @(negedge clock);
                chk(32'(bypass_sw), 32'(s != 1 && s != 2));
                chk(32'(buf_en), 32'(s == 1));
                chk({pga_en, pga_in_sw, pga_out_sw}, {3{s == 2}});
                chk(32'(bypass_sw) + 32'(buf_en) + 32'(pga_en), 32'h1);
                chk(32'(pga_gain), (s == 2) ? 32'(g) : 32'h0);
                chk(32'(dgain), (s == 2 || g == 0) ? 32'h0 : (g == 1) ? 32'h1 : 32'h2);
            end
        end
    endtask
    // one word through, wait for its result
    task automatic send_and_check(input logic [31:0] w, input logic [23:0] exp, input logic bip);
        int n;
        n = 0;
        u_mod.send_word(w);
        do begin
            @(negedge clock);
            n++;
        end while (result_valid !== 1'b1 && n < 8);
        chk(32'(result_valid), 32'h1);
        chk(32'(result), 32'(exp));
        chk(32'(result_bipolar), 32'(bip));
    endtask
    // bit field per path and gain code
    task automatic test_gains();
        logic [31:0] w;
        for (int s = 0; s < 3; s++) begin
            for (int g = 0; g < 8; g++) begin
                @(negedge clock);
                path_sel = 2'(s);
                gain_code = 3'(g);
                bipolar = g[0];
                filter_sinc4 = g[1];
                single_cycle = g[2] & ~g[1];
                w = {3'(g), 2'(s), 27'h5a3c6e1} ^ 32'hc3a50f96;
                send_and_check(w, exp_res(s, g, w), g[0]);
            end
        end
    endtask
    // sinc4 single-cycle: only the fourth word yields a result
    task automatic test_sinc4(input logic [1:0] gap);
        int hits;
        hits = 0;
        @(negedge clock);
        path_sel = 2'h0;
        gain_code = 3'h1;
        filter_sinc4 = 1'b1;
        single_cycle = 1'b1;
        gap_cycles = gap;
        for (int i = 0; i < 4; i++) u_mod.send_word(32'h1f2e3d4c + 32'(i));
        repeat (24) begin
            @(negedge clock);
            hits += int'(result_valid === 1'b1);
        end
        chk(32'(hits), 32'h1);
        chk(32'(result), 32'(exp_res(0, 1, 32'h1f2e3d4f)));
        filter_sinc4 = 1'b0;
        single_cycle = 1'b0;
        gap_cycles = 2'h0;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset in mid-run: outputs back to idle, quarter-rate count restarts
    task automatic test_reset_mid();
        @(negedge clock);
        path_sel = 2'h1;
        gain_code = 3'h0;
        filter_sinc4 = 1'b1;
        single_cycle = 1'b1;
        u_mod.send_word(32'h0bad1dea);
        u_mod.send_word(32'h2468ace0);
        repeat (4) @(negedge clock);
        arst_n = 1'b0;
        @(negedge clock);
        chk({bypass_sw, buf_en, pga_en, pga_in_sw, pga_out_sw}, 32'h10);
        chk({pga_gain, dgain, result_valid, result_bipolar}, 32'h0);
        chk(32'(result), 32'h0);
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
    endtask
    // free-running clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // main sequence
    initial begin
        arst_n = 1'b0;
        path_sel = 2'h2;
        gain_code = 3'h3;
        bipolar = 1'b1;
        filter_sinc4 = 1'b0;
        single_cycle = 1'b0;
        gap_cycles = 2'h0;
        repeat (12) @(negedge clock);
        chk({bypass_sw, buf_en, pga_en, pga_gain, dgain, result_valid}, 32'h100);
        arst_n = 1'b1;
        test_paths();
        test_gains();
        test_sinc4(2'h0);
        test_sinc4(2'h2);
        test_reset_mid();
        test_sinc4(2'h0);
        tally_and_finish();
    end
    // hang guard, well past the expected run
    initial begin
        #400000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
